// ==== rtl/irq_mask2_pkg.sv ====
// Purpose: Shared constants for the second interrupt mask and temperature interrupt mode block.
// Assumes: APB with 32-bit data, one word per register, decoded on the full byte address (status two at 02h).
// Notes:   Only the low eight bits of each register are used; upper bits read as zero.
package irq_mask2_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam int          SRC_W           = 6;
  localparam int          REG_W           = 8;
  // Register byte addresses.
  localparam logic [7:0]  OFS_STATUS_TWO  = 8'h02;
  localparam logic [7:0]  OFS_MASK_TWO    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h40;
  localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h44;
  localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h48;
  // Reset values.
  localparam logic [7:0]  MASK_TWO_RST    = 8'h00;
  localparam logic [5:0]  STATUS_RST      = 6'h00;
  localparam logic [1:0]  IRQ_RST         = 2'h0;
  // Field positions in the mask and status registers.
  localparam int          BIT_HOT         = 0;
  localparam int          BIT_BOARD       = 1;
  localparam int          BIT_FAN1        = 2;
  localparam int          BIT_FAN2        = 3;
  localparam int          BIT_ENCL        = 4;
  localparam int          BIT_OVT         = 5;
  localparam int          BIT_HOT_MODE    = 6;
  localparam int          BIT_OVT_MODE    = 7;
  // Local interrupt event bit positions.
  localparam int          EV_SET          = 0;
  localparam int          EV_ALERT        = 1;
  localparam logic [31:0] RD_ERR_DATA     = 32'h00000000;
endpackage : irq_mask2_pkg

// ==== rtl/irq_mask2_temp_irq_modes.sv ====
// Purpose: Second interrupt mask register, interrupt status two and temperature interrupt modes.
// Assumes: Conversion results arrive as one-cycle pulses with above-hot and below-hysteresis levels.
// Notes:   Reading status two over APB clears it; the alert output is active low open drain.
//
// Summary of operation
// (RL1) Mask register two sits at offset 04h and resets to all zeros.
// (RL2) Bits 0 to 5 each mask one status source from the alert line.
// (RL3) Bit 6 picks hot mode, bit 7 overtemp mode; one means one-time.
// (RL4) Default mode: flag sets each conversion above hot until below hysteresis.
// (RL5) One-time mode: a single flag on first rise above hot limit.
// (RL6) One-time mode: falling below hysteresis flags once, then waits for hot again.
// (RL7) Status read clears flags; one-time flag resets only on a new crossing.
// (RL8) Hot temperature status is bit 0 of status two, mode from bit 6.
// (RL9) Alert active while any unmasked status bit is set.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module irq_mask2_temp_irq_modes (
  // Clock and reset.
  input  wire logic                               clock,
  input  wire logic                               sys_rst,
  // APB slave.
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [irq_mask2_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [irq_mask2_pkg::DATA_W-1:0]   pwdata,
  output logic      [irq_mask2_pkg::DATA_W-1:0]   prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Conversion results for the two temperature sources.
  input  wire logic                               conv_done,
  input  wire logic                               hot_above,
  input  wire logic                               hot_below_hyst,
  input  wire logic                               ovt_above,
  input  wire logic                               ovt_below_hyst,
  // Other source events, one-cycle pulses.
  input  wire logic                               board_thermal_alert,
  input  wire logic                               fan1_event,
  input  wire logic                               fan2_event,
  input  wire logic                               enclosure_open,
  // Alert line and local interrupt.
  output logic                                    alert_n_oe,
  output logic                                    irq
);

  // Access decode shared by the register paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [7:0]                               mask_r, mask_nxt;
  logic [5:0]                               stat_r, stat_nxt;
  logic [1:0]                               armed_r, armed_nxt;
  logic [1:0]                               ist_r, ist_nxt;
  logic [1:0]                               ien_r, ien_nxt;
  logic [irq_mask2_pkg::DATA_W-1:0]         prdata_r, prdata_nxt;
  logic                                     pready_r, pready_nxt;
  logic                                     pslverr_r, pslverr_nxt;
  logic                                     alert_r, alert_nxt;
  logic                                     irq_r, irq_nxt;
  logic                                     acc, wr, rd, mapped, stat_rd;
  logic [1:0]                               tflag;
  logic [1:0]                               above, below;
  logic [1:0]                               mode;
  logic [5:0]                               setv;

  // Bus qualifiers; every access completes one cycle after its first access cycle.
  always_comb
  begin
    acc     = psel && penable && !pready_r;
    wr      = acc && pwrite;
    rd      = acc && !pwrite;
    mapped  = hit(paddr, irq_mask2_pkg::OFS_STATUS_TWO) || hit(paddr, irq_mask2_pkg::OFS_MASK_TWO) ||
              hit(paddr, irq_mask2_pkg::OFS_IRQ_STATUS) || hit(paddr, irq_mask2_pkg::OFS_IRQ_ENABLE) ||
              hit(paddr, irq_mask2_pkg::OFS_IRQ_CLEAR);
    stat_rd = rd && hit(paddr, irq_mask2_pkg::OFS_STATUS_TWO); // [RL7]
  end

  // Temperature flag logic per source, in default or one-time mode.
  always_comb
  begin
    above     = {ovt_above, hot_above};
    below     = {ovt_below_hyst, hot_below_hyst};
    mode      = {mask_r[irq_mask2_pkg::BIT_OVT_MODE], mask_r[irq_mask2_pkg::BIT_HOT_MODE]}; // [RL3]
    armed_nxt = armed_r;
    tflag     = 2'h0;
    for (int i = 0; i < 2; i++)
    begin
      if (conv_done)
      begin
        if (!mode[i])
        begin
          tflag[i]     = above[i] || (armed_r[i] && !below[i]); // [RL4]
          armed_nxt[i] = above[i] || (armed_r[i] && !below[i]);
        end
        else if (!armed_r[i] && above[i])
        begin
          tflag[i]     = 1'b1; // [RL5]
          armed_nxt[i] = 1'b1;
        end
        else if (armed_r[i] && below[i])
        begin
          tflag[i]     = 1'b1; // [RL6]
          armed_nxt[i] = 1'b0;
        end
      end
    end
  end

  // Status two: events set bits, a read clears them, a set in the read cycle survives.
  always_comb
  begin
    setv = 6'h00;
    setv[irq_mask2_pkg::BIT_HOT]   = tflag[0]; // [RL8]
    setv[irq_mask2_pkg::BIT_BOARD] = board_thermal_alert;
    setv[irq_mask2_pkg::BIT_FAN1]  = fan1_event;
    setv[irq_mask2_pkg::BIT_FAN2]  = fan2_event;
    setv[irq_mask2_pkg::BIT_ENCL]  = enclosure_open;
    setv[irq_mask2_pkg::BIT_OVT]   = tflag[1];
    stat_nxt = (stat_rd ? 6'h00 : stat_r) | setv; // [RL7]
  end

  // Mask register two and local interrupt registers.
  always_comb
  begin
    mask_nxt = mask_r;
    ien_nxt  = ien_r;
    if (wr && hit(paddr, irq_mask2_pkg::OFS_MASK_TWO))
    begin
      mask_nxt = pwdata[irq_mask2_pkg::REG_W-1:0]; // [RL1]
    end
    if (wr && hit(paddr, irq_mask2_pkg::OFS_IRQ_ENABLE))
    begin
      ien_nxt = pwdata[1:0];
    end
  end

  // Local interrupt status: a clear write drops bits, an event in the same cycle still sets them.
  always_comb
  begin
    ist_nxt = ist_r;
    if (wr && hit(paddr, irq_mask2_pkg::OFS_IRQ_CLEAR))
    begin
      ist_nxt = ist_r & ~pwdata[1:0];
    end
    ist_nxt[irq_mask2_pkg::EV_SET]   = ist_nxt[irq_mask2_pkg::EV_SET] | (|setv);
    ist_nxt[irq_mask2_pkg::EV_ALERT] = ist_nxt[irq_mask2_pkg::EV_ALERT] | (alert_nxt && !alert_r);
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  // Alert drive from unmasked status bits.
  always_comb
  begin
    alert_nxt = |(stat_nxt & ~mask_nxt[irq_mask2_pkg::SRC_W-1:0]); // [RL2] [RL9]
  end

  // APB answer: one wait cycle per access phase, error on unmapped addresses.
  always_comb
  begin
    prdata_nxt  = irq_mask2_pkg::RD_ERR_DATA;
    pready_nxt  = acc;
    pslverr_nxt = acc && !mapped;
    if (rd)
    begin
      if (hit(paddr, irq_mask2_pkg::OFS_STATUS_TWO))
      begin
        prdata_nxt = {{(irq_mask2_pkg::DATA_W-irq_mask2_pkg::SRC_W){1'b0}}, stat_r};
      end
      else if (hit(paddr, irq_mask2_pkg::OFS_MASK_TWO))
      begin
        prdata_nxt = {24'h000000, mask_r};
      end
      else if (hit(paddr, irq_mask2_pkg::OFS_IRQ_STATUS))
      begin
        prdata_nxt = {{(irq_mask2_pkg::DATA_W-$bits(ist_r)){1'b0}}, ist_r};
      end
      else if (hit(paddr, irq_mask2_pkg::OFS_IRQ_ENABLE))
      begin
        prdata_nxt = {{(irq_mask2_pkg::DATA_W-$bits(ien_r)){1'b0}}, ien_r};
      end
    end
  end

  // State registers with synchronous reset.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mask_r    <= irq_mask2_pkg::MASK_TWO_RST; // [RL1]
      stat_r    <= irq_mask2_pkg::STATUS_RST;
      armed_r   <= irq_mask2_pkg::IRQ_RST;
      ist_r     <= irq_mask2_pkg::IRQ_RST;
      ien_r     <= irq_mask2_pkg::IRQ_RST;
      prdata_r  <= irq_mask2_pkg::RD_ERR_DATA;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      alert_r   <= 1'b0;
      irq_r     <= 1'b0;
    end
    else
    begin
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      armed_r   <= armed_nxt;
      ist_r     <= ist_nxt;
      ien_r     <= ien_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      alert_r   <= alert_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign alert_n_oe = alert_r;
  assign irq        = irq_r;

  // Mask register is zero in the cycle after reset.
  AST_MASK_RESET: assert property (@(posedge clock) sys_rst |=> (mask_r == irq_mask2_pkg::MASK_TWO_RST)) // [RL1]
    else $error("mask not cleared by reset");

  // A fully masked status keeps the alert inactive.
  AST_MASK_BLOCKS: assert property (@(posedge clock) disable iff (sys_rst) // [RL2]
    (stat_r & ~mask_r[irq_mask2_pkg::SRC_W-1:0]) == '0 |-> !alert_n_oe)
    else $error("masked source drove alert");

  // Mode bits follow a write to the mask register.
  AST_MODE_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // [RL3]
    wr && paddr == irq_mask2_pkg::OFS_MASK_TWO |=>
    mask_r[irq_mask2_pkg::BIT_OVT_MODE] == $past(pwdata[irq_mask2_pkg::BIT_OVT_MODE]) &&
    mask_r[irq_mask2_pkg::BIT_HOT_MODE] == $past(pwdata[irq_mask2_pkg::BIT_HOT_MODE]))
    else $error("mode bits not written");

  // Default mode repeats the hot flag while above hot.
  AST_DEFAULT_REPEAT: assert property (@(posedge clock) disable iff (sys_rst) // [RL4]
    conv_done && hot_above && !mask_r[irq_mask2_pkg::BIT_HOT_MODE] |=> stat_r[irq_mask2_pkg::BIT_HOT])
    else $error("default mode missed hot flag");

  // One-time mode flags nothing while armed and not below hysteresis.
  AST_ONCE_QUIET: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    conv_done && mask_r[irq_mask2_pkg::BIT_HOT_MODE] && armed_r[0] && !hot_below_hyst |-> !tflag[0])
    else $error("one-time mode repeated flag");

  // One-time mode flags the fall below hysteresis and disarms.
  AST_ONCE_FALL: assert property (@(posedge clock) disable iff (sys_rst) // [RL6]
    conv_done && mask_r[irq_mask2_pkg::BIT_HOT_MODE] && armed_r[0] && hot_below_hyst |=>
    stat_r[irq_mask2_pkg::BIT_HOT] && !armed_r[0])
    else $error("one-time fall not flagged");

  // A status read clears bits with no new event.
  AST_READ_CLEAR: assert property (@(posedge clock) disable iff (sys_rst) // [RL7]
    stat_rd && setv == '0 |=> stat_r == '0)
    else $error("status read did not clear");

  // Hot flag lands on bit zero of status two.
  AST_HOT_BIT: assert property (@(posedge clock) disable iff (sys_rst) // [RL8]
    tflag[0] |=> stat_r[irq_mask2_pkg::BIT_HOT])
    else $error("hot flag not on bit zero");

  // An unmasked set bit drives the alert.
  AST_ALERT_ON: assert property (@(posedge clock) disable iff (sys_rst) // [RL9]
    (stat_r & ~mask_r[irq_mask2_pkg::SRC_W-1:0]) != '0 |-> alert_n_oe)
    else $error("alert not driven");

  // One-time mode arms and flags on the first conversion above hot.
  AST_ONCE_ARM: assert property (@(posedge clock) disable iff (sys_rst) // [RL5]
    conv_done && mask_r[irq_mask2_pkg::BIT_HOT_MODE] && !armed_r[0] && hot_above |=>
    stat_r[irq_mask2_pkg::BIT_HOT] && armed_r[0])
    else $error("one-time first crossing not flagged");

  // Default mode raises no hot flag on a conversion below hysteresis.
  AST_DEFAULT_QUIET: assert property (@(posedge clock) disable iff (sys_rst) // [RL4]
    conv_done && !mask_r[irq_mask2_pkg::BIT_HOT_MODE] && !hot_above && hot_below_hyst |-> !tflag[0])
    else $error("default mode flagged below hysteresis");

  // Overtemp default mode flags each conversion above its limit.
  AST_OVT_DEFAULT_REPEAT: assert property (@(posedge clock) disable iff (sys_rst) // [RL3]
    conv_done && ovt_above && !mask_r[irq_mask2_pkg::BIT_OVT_MODE] |=> stat_r[irq_mask2_pkg::BIT_OVT])
    else $error("overtemp default mode missed flag");

  // Overtemp one-time mode stays quiet without a new crossing.
  AST_OVT_ONCE_QUIET: assert property (@(posedge clock) disable iff (sys_rst) // [RL7]
    conv_done && mask_r[irq_mask2_pkg::BIT_OVT_MODE] && armed_r[1] && !ovt_below_hyst |-> !tflag[1])
    else $error("overtemp one-time mode repeated flag");

  // Every access phase is answered one cycle after it is taken.
  AST_APB_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
    psel && penable && !pready |=> pready)
    else $error("access phase not answered");

  // The ready answer lasts exactly one cycle.
  AST_PREADY_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready held too long");

  // An error answer only comes together with ready.
  AST_SLVERR_READY: assert property (@(posedge clock) disable iff (sys_rst)
    pslverr |-> pready)
    else $error("error without ready");

  // Read data stays zero outside the answer cycle.
  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
    !pready |-> prdata == irq_mask2_pkg::RD_ERR_DATA)
    else $error("read data outside answer");

  // The local interrupt follows enabled status bits.
  AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (sys_rst)
    irq == (|(ist_r & ien_r)))
    else $error("interrupt level mismatch");

endmodule : irq_mask2_temp_irq_modes

// ==== verif/apb_host.sv ====
// Purpose: APB host model that stands in for the register-reading host.
// Assumes: One request pulse per transfer, given while idle.
// Notes:   Address and data are scrambled once released.
`timescale 1ns/10ps
module apb_host (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Request side.
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wd,
  output logic             done,
  output logic [31:0]      rd,
  output logic             err,
  // APB master.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Setup, then access held until pready; the answer is taken at that edge only.
  always_ff @(posedge clock)
  begin
    done <= 1'b0;
    if (sys_rst)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
    else if (psel && penable && pready)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      done    <= 1'b1;
      rd      <= prdata;
      err     <= pslverr;
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
    end
    else if (psel)
      penable <= 1'b1;
    else if (req)
    begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wd;
    end
  end
endmodule : apb_host

// ==== verif/irq_mask2_temp_irq_modes_test.sv ====
// Purpose: Self-checking bench for the mask two and temperature mode block.
// Assumes: Register traffic goes through the host model.
// Notes:   Each scenario task drives and judges on its own.
`timescale 1ns/10ps
module irq_mask2_temp_irq_modes_test;
  localparam logic [7:0] M = irq_mask2_pkg::OFS_MASK_TWO;
  localparam logic [7:0] S = irq_mask2_pkg::OFS_STATUS_TWO;
  logic        clock = 1'b0, sys_rst = 1'b1, req = 1'b0, wr = 1'b0, conv = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  lv = 4'h0, ev = 4'h0;
  logic        done, err, psel, penable, pwrite, pready, pslverr, alert_n_oe, irq;
  logic [7:0]  paddr;
  logic [31:0] rd, pwdata, prdata;
  int          fails = 0, tests_run = 0;
  // Clock of 5 ns period.
  always #2.5 clock = ~clock;
  apb_host host (.clock(clock), .sys_rst(sys_rst), .req(req), .wr(wr), .addr(addr), .wd(wd), .done(done),
    .rd(rd), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  irq_mask2_temp_irq_modes dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv), .hot_above(lv[3]), .hot_below_hyst(lv[2]), .ovt_above(lv[1]), .ovt_below_hyst(lv[0]),
    .board_thermal_alert(ev[0]), .fan1_event(ev[1]), .fan2_event(ev[2]), .enclosure_open(ev[3]),
    .alert_n_oe(alert_n_oe), .irq(irq));
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One register transfer; the wait for completion is bounded.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req  <= 1'b1;
    wr   <= w;
    addr <= a;
    wd   <= d;
    @(posedge clock);
    req <= 1'b0;
    for (int n = 0; n < 20 && done !== 1'b1; n++)
      @(negedge clock);
    if (done !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask : xfer
  task automatic rd2(input logic [31:0] e);
    xfer(1'b0, S, 32'h0);
    chk(rd, e);
  endtask : rd2
  task automatic ep(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= 4'h0;
    repeat (3) @(negedge clock);
  endtask : ep
  // Conversion pulse for source s with above-hot a and below-hysteresis b.
  task automatic cv(input int s, input logic a, input logic b);
    @(posedge clock);
    conv <= 1'b1;
    lv   <= (s != 0) ? {2'b00, a, b} : {a, b, 2'b00};
    @(posedge clock);
    conv <= 1'b0;
    repeat (3) @(negedge clock);
  endtask : cv
  task automatic t_reset();
    xfer(1'b0, M, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, M, 32'h000000ff);
    xfer(1'b0, M, 32'h0);
    chk(rd, 32'h000000ff);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    xfer(1'b0, M, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_mask();
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, M, 32'h1 << (i + 1));
      ep(i);
      chk({31'h0, alert_n_oe}, 32'h0);
      xfer(1'b1, M, 32'h0);
      repeat (2) @(negedge clock);
      chk({31'h0, alert_n_oe}, 32'h1);
      rd2(32'h1 << (i + 1));
      repeat (2) @(negedge clock);
      chk({31'h0, alert_n_oe}, 32'h0);
    end
  endtask : t_mask
  task automatic t_temp(input int s);
    logic [31:0] sb;
    sb = (s != 0) ? 32'h20 : 32'h01;
    xfer(1'b1, M, sb);
    cv(s, 1'b0, 1'b1);
    xfer(1'b0, S, 32'h0);
    cv(s, 1'b1, 1'b0);
    chk({31'h0, alert_n_oe}, 32'h0);
    rd2(sb);
    cv(s, 1'b0, 1'b0);
    rd2(sb);
    cv(s, 1'b0, 1'b1);
    xfer(1'b0, S, 32'h0);
    cv(s, 1'b0, 1'b1);
    rd2(32'h0);
    xfer(1'b1, M, (s != 0) ? 32'h80 : 32'h40);
    cv(s, 1'b1, 1'b0);
    chk({31'h0, alert_n_oe}, 32'h1);
    rd2(sb);
    cv(s, 1'b1, 1'b0);
    rd2(32'h0);
    cv(s, 1'b0, 1'b1);
    rd2(sb);
    cv(s, 1'b0, 1'b1);
    rd2(32'h0);
    cv(s, 1'b1, 1'b0);
    rd2(sb);
    cv(s, 1'b0, 1'b1);
    xfer(1'b0, S, 32'h0);
  endtask : t_temp
  task automatic t_irq();
    xfer(1'b1, irq_mask2_pkg::OFS_IRQ_CLEAR, 32'h3);
    xfer(1'b1, irq_mask2_pkg::OFS_IRQ_ENABLE, 32'h3);
    xfer(1'b0, irq_mask2_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk(rd, 32'h3);
    chk({31'h0, irq}, 32'h0);
    ep(1);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, irq_mask2_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    xfer(1'b0, S, 32'h0);
    chk(rd, 32'h4);
    xfer(1'b1, irq_mask2_pkg::OFS_IRQ_CLEAR, 32'h3);
    repeat (2) @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b0, irq_mask2_pkg::OFS_IRQ_CLEAR, 32'h0);
    chk(rd, 32'h0);
  endtask : t_irq
  // Reset for 16 cycles, then the scenarios in turn.
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_mask();
    t_temp(0);
    t_temp(1);
    t_irq();
    end_of_test();
  end
endmodule : irq_mask2_temp_irq_modes_test
